/* File: mcu_glue_pkg.sv */
package mcu_glue_pkg;

  // ==========================================================================
  // clocking
  localparam int unsigned CORE_HZ       = 200_000_000;
  localparam int unsigned XTAL_HZ       = 4_000_000;
  localparam int unsigned XTAL_DIV      = 4;
  localparam int unsigned XTAL_HALF_CYC = CORE_HZ / XTAL_HZ / 2;
  localparam int unsigned DLY_NS        = 10;
  localparam int unsigned DLY_CYC       = (DLY_NS * (CORE_HZ / 1_000_000) + 999) / 1000;

  // ==========================================================================
  // port widths and bit positions
  localparam int unsigned PRI_W       = 8;
  localparam int unsigned AUX_W       = 5;
  localparam int unsigned AUX_KEY     = 0;
  localparam int unsigned AUX_SPARE   = 1;
  localparam int unsigned AUX_DVAL    = 2;
  localparam int unsigned AUX_DREC    = 3;
  localparam int unsigned AUX_DIR     = 4;
  localparam int unsigned MODE_LSB    = 0;
  localparam int unsigned MODE_W      = 3;
  localparam logic [2:0]  MODE_EXPECT = 3'h2;
  localparam logic [2:0]  MODE_RST    = 3'h0;
  localparam int unsigned SYN_STB_BIT = 0;

  // ==========================================================================
  // register map, byte addresses
  localparam logic [11:0] PRI_OUT_OFS   = 12'h000;
  localparam logic [11:0] PRI_DIR_OFS   = 12'h004;
  localparam logic [11:0] PRI_PIN_OFS   = 12'h008;
  localparam logic [11:0] AUX_OUT_OFS   = 12'h00c;
  localparam logic [11:0] AUX_DIR_OFS   = 12'h010;
  localparam logic [11:0] AUX_PIN_OFS   = 12'h014;
  localparam logic [11:0] STATUS_OFS    = 12'h018;
  localparam logic [11:0] EVENT_OFS     = 12'h01c;
  localparam logic [11:0] OUTLATCH_OFS  = 12'h020;
  localparam logic [11:0] SYNTH_OFS     = 12'h024;
  localparam logic [11:0] STBY_OFS      = 12'h040;
  localparam logic [11:0] SAVED_OFS     = 12'h060;
  localparam int unsigned STBY_WORDS    = 4;

  // ==========================================================================
  // event bits
  localparam int unsigned EV_KEY  = 0;
  localparam int unsigned EV_DIR  = 1;
  localparam int unsigned EV_NMI  = 2;
  localparam int unsigned EV_DREC = 3;
  localparam int unsigned EV_W    = 4;

  // ==========================================================================
  // memory strobes, all active low
  typedef struct packed {
    logic ram_cs_n;
    logic ram_we_n;
    logic ram_oe_n;
    logic rom_ce_n;
  } mem_ctl_s;

endpackage

/* File: mcu_glue.sv */
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps

module mcu_glue #(
  parameter int unsigned STBY_N = mcu_glue_pkg::STBY_WORDS
) (
  input  wire logic                         CORE_CLK_I,
  input  wire logic                         NRST_I,
  input  wire logic                         PSEL_I,
  input  wire logic                         PENABLE_I,
  input  wire logic                         PWRITE_I,
  input  wire logic [11:0]                  PADDR_I,
  input  wire logic [31:0]                  PWDATA_I,
  output logic      [31:0]                  PRDATA_O,
  output logic                              PREADY_O,
  output logic                              PSLVERR_O,
  input  wire logic [mcu_glue_pkg::PRI_W-1:0] PRI_PORT_I,
  output logic      [mcu_glue_pkg::PRI_W-1:0] PRI_PORT_O,
  output logic      [mcu_glue_pkg::PRI_W-1:0] PRI_PORT_OE_O,
  input  wire logic [mcu_glue_pkg::AUX_W-1:0] AUX_PORT_I,
  output logic      [mcu_glue_pkg::AUX_W-1:0] AUX_PORT_O,
  output logic      [mcu_glue_pkg::AUX_W-1:0] AUX_PORT_OE_O,
  input  wire logic                         IFACE_IRQ_N_I,
  input  wire logic                         NMI_N_I,
  output logic                              MASKABLE_IRQ_N_O,
  input  wire logic                         PROC_RW_I,
  input  wire logic [7:0]                   PROC_DATA_I,
  input  wire logic                         RAM_SEL_N_I,
  input  wire logic                         ROM_SEL_N_I,
  input  wire logic                         OPORT_SEL_N_I,
  output logic                              SYS_CLK_O,
  output logic                              DLY_CLK_O,
  output logic                              DECODE_EN_O,
  output mcu_glue_pkg::mem_ctl_s            MEM_CTL_O,
  output logic      [7:0]                   OUT_PORT_O,
  output logic      [7:0]                   SYNTH_DATA_O,
  output logic                              SYNTH_STROBE_O,
  output logic      [mcu_glue_pkg::MODE_W-1:0] MODE_O
);

  localparam int unsigned XH    = mcu_glue_pkg::XTAL_HALF_CYC;
  localparam int unsigned DLY   = mcu_glue_pkg::DLY_CYC;
  localparam int unsigned PW    = mcu_glue_pkg::PRI_W;
  localparam int unsigned AW    = mcu_glue_pkg::AUX_W;
  localparam int unsigned EW    = mcu_glue_pkg::EV_W;
  localparam int unsigned SIW   = $clog2(STBY_N);

  // ==========================================================================
  // clock generation
  logic [7:0]     xtal_cnt_r;
  logic           xtal_r;
  logic [1:0]     div_r;
  logic           sys_r;
  logic           sys_prev_r;
  logic [DLY-1:0] dly_r;
  logic           dly_prev_r;
  logic           sys_rise;
  logic           sys_fall;
  logic           dly_fall;
  logic           xtal_rise;
  assign xtal_rise = (xtal_cnt_r == 8'(XH - 1)) && !xtal_r;
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      xtal_cnt_r <= 8'h00;
      xtal_r     <= 1'b0;
    end else if (xtal_cnt_r == 8'(XH - 1)) begin
      xtal_cnt_r <= 8'h00;
      xtal_r     <= !xtal_r;
    end else begin
      xtal_cnt_r <= xtal_cnt_r + 8'h01;
    end
  end

  // two crystal periods low, two high
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      div_r <= 2'h0;
    end else if (xtal_rise) begin
      div_r <= div_r + 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      sys_r      <= 1'b0;
      sys_prev_r <= 1'b0;
      dly_r      <= '0;
      dly_prev_r <= 1'b0;
    end else begin
      sys_r      <= div_r[1];
      sys_prev_r <= sys_r;
      dly_r      <= {dly_r[DLY-2:0], sys_r};
      dly_prev_r <= dly_r[DLY-1];
    end
  end

  assign sys_rise  = sys_r && !sys_prev_r;
  assign sys_fall  = !sys_r && sys_prev_r;
  assign dly_fall  = !dly_r[DLY-1] && dly_prev_r;
  assign SYS_CLK_O = sys_r;
  assign DLY_CLK_O = dly_r[DLY-1];

  // ==========================================================================
  // decoder enable and device selection
  logic dec_en_r;
  logic ram_sel_r;
  logic rom_sel_r;
  logic oport_sel_r;

  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      dec_en_r <= 1'b0;
    end else begin
      dec_en_r <= !dly_r[DLY-2] && NRST_I;
    end
  end
  assign DECODE_EN_O = dec_en_r;
  // decoder settles slowly, so it may only open a select at the data edge
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      ram_sel_r <= 1'b0;
      rom_sel_r <= 1'b0;
    end else if (sys_rise) begin
      ram_sel_r <= !RAM_SEL_N_I;
      rom_sel_r <= !ROM_SEL_N_I;
    end else if (dly_fall) begin
      ram_sel_r <= 1'b0;
      rom_sel_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      oport_sel_r <= 1'b0;
    end else if (sys_rise) begin
      oport_sel_r <= !OPORT_SEL_N_I && !PROC_RW_I;
    end else if (sys_fall) begin
      oport_sel_r <= 1'b0;
    end
  end

  always_comb begin
    MEM_CTL_O.ram_cs_n = !(ram_sel_r && dly_r[DLY-1]);
    MEM_CTL_O.rom_ce_n = !(rom_sel_r && dly_r[DLY-1]);
    MEM_CTL_O.ram_we_n = !(ram_sel_r && !PROC_RW_I && sys_r);
    MEM_CTL_O.ram_oe_n = !(ram_sel_r && PROC_RW_I && dly_r[DLY-1]);
  end

  // ==========================================================================
  // output port latch and synthesizer latch
  logic [7:0] out_latch_r;
  logic [7:0] synth_r;

  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      out_latch_r <= 8'h00;
    end else if (sys_fall && oport_sel_r) begin
      out_latch_r <= PROC_DATA_I;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      synth_r <= 8'h00;
    end else if (out_latch_r[mcu_glue_pkg::SYN_STB_BIT]) begin
      synth_r <= PROC_DATA_I;
    end
  end

  assign OUT_PORT_O     = out_latch_r;
  assign SYNTH_DATA_O   = synth_r;
  assign SYNTH_STROBE_O = out_latch_r[mcu_glue_pkg::SYN_STB_BIT];

  // ==========================================================================
  // ports
  logic [PW-1:0] pri_out_r;
  logic [PW-1:0] pri_dir_r;
  logic [AW-1:0] aux_out_r;
  logic [AW-1:0] aux_dir_r;
  logic [AW-1:0] aux_mask;
  always_comb begin
    aux_mask = '1;
    aux_mask[mcu_glue_pkg::AUX_SPARE] = 1'b0;
  end
  assign PRI_PORT_O    = pri_out_r;
  assign PRI_PORT_OE_O = pri_dir_r;
  assign AUX_PORT_O    = aux_out_r & aux_mask;
  assign AUX_PORT_OE_O = aux_dir_r & aux_mask;

  // ==========================================================================
  // mode strap
  logic                    rst_seen_r;
  logic [2:0]              mode_r;
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      rst_seen_r <= 1'b0;
      mode_r     <= mcu_glue_pkg::MODE_RST;
    end else begin
      rst_seen_r <= 1'b1;
      if (!rst_seen_r) begin
        mode_r <= AUX_PORT_I[mcu_glue_pkg::MODE_LSB +: 3];
      end
    end
  end
  assign MODE_O = mode_r;

  // ==========================================================================
  // interrupts and events
  logic [AW-1:0]  aux_prev_r;
  logic           nmi_prev_r;
  logic [EW-1:0]  ev_r;
  logic [EW-1:0]  ev_set;
  logic [EW-1:0]  ev_clr;
  logic           nmi_fall;

  // maskable line is pure glue, no mask here
  assign MASKABLE_IRQ_N_O = AUX_PORT_I[mcu_glue_pkg::AUX_KEY] && IFACE_IRQ_N_I;
  assign nmi_fall = nmi_prev_r && !NMI_N_I;
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      aux_prev_r <= '1;
      nmi_prev_r <= 1'b1;
    end else begin
      aux_prev_r <= AUX_PORT_I;
      nmi_prev_r <= NMI_N_I;
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[mcu_glue_pkg::EV_KEY]  = aux_prev_r[mcu_glue_pkg::AUX_KEY]
                                    && !AUX_PORT_I[mcu_glue_pkg::AUX_KEY];
    ev_set[mcu_glue_pkg::EV_DIR]  = aux_prev_r[mcu_glue_pkg::AUX_DIR]
                                    && !AUX_PORT_I[mcu_glue_pkg::AUX_DIR];
    ev_set[mcu_glue_pkg::EV_DREC] = !aux_prev_r[mcu_glue_pkg::AUX_DREC]
                                    && AUX_PORT_I[mcu_glue_pkg::AUX_DREC];
    ev_set[mcu_glue_pkg::EV_NMI]  = nmi_fall;
  end

  // ==========================================================================
  // standby ram
  logic [7:0] stby_r  [STBY_N];
  logic [7:0] saved_r [STBY_N];
  // ==========================================================================
  // apb slave, one wait state
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        acc;
  logic        wr_done;
  assign acc     = PSEL_I && PENABLE_I && !pready_r;
  assign wr_done = PSEL_I && PENABLE_I && pready_r && PWRITE_I && !pslverr_r;
  function automatic logic mapped(input logic [11:0] a);
    logic m;
    m = 1'b0;
    if (a == mcu_glue_pkg::PRI_OUT_OFS || a == mcu_glue_pkg::PRI_DIR_OFS) begin
      m = 1'b1;
    end else if (a == mcu_glue_pkg::PRI_PIN_OFS || a == mcu_glue_pkg::AUX_OUT_OFS) begin
      m = 1'b1;
    end else if (a == mcu_glue_pkg::AUX_DIR_OFS || a == mcu_glue_pkg::AUX_PIN_OFS) begin
      m = 1'b1;
    end else if (a == mcu_glue_pkg::STATUS_OFS || a == mcu_glue_pkg::EVENT_OFS) begin
      m = 1'b1;
    end else if (a == mcu_glue_pkg::OUTLATCH_OFS || a == mcu_glue_pkg::SYNTH_OFS) begin
      m = 1'b1;
    end else if (a >= mcu_glue_pkg::STBY_OFS && a < mcu_glue_pkg::STBY_OFS + 12'(4 * STBY_N)) begin
      m = 1'b1;
    end else if (a >= mcu_glue_pkg::SAVED_OFS && a < mcu_glue_pkg::SAVED_OFS + 12'(4 * STBY_N)) begin
      m = 1'b1;
    end
    return m && (a[1:0] == 2'h0);
  endfunction
  always_comb begin
    ev_clr = '0;
    if (wr_done && PADDR_I == mcu_glue_pkg::EVENT_OFS) begin
      ev_clr = PWDATA_I[EW-1:0];
    end
  end

  // a new event in the clearing cycle survives
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      ev_r <= '0;
    end else begin
      ev_r <= (ev_r & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      pri_out_r <= '0;
      pri_dir_r <= '0;
      aux_out_r <= '0;
      aux_dir_r <= '0;
    end else if (wr_done) begin
      if (PADDR_I == mcu_glue_pkg::PRI_OUT_OFS) begin
        pri_out_r <= PWDATA_I[PW-1:0];
      end else if (PADDR_I == mcu_glue_pkg::PRI_DIR_OFS) begin
        pri_dir_r <= PWDATA_I[PW-1:0];
      end else if (PADDR_I == mcu_glue_pkg::AUX_OUT_OFS) begin
        aux_out_r <= PWDATA_I[AW-1:0];
      end else if (PADDR_I == mcu_glue_pkg::AUX_DIR_OFS) begin
        aux_dir_r <= PWDATA_I[AW-1:0] & aux_mask;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < STBY_N; gi++) begin : g_stby
      always_ff @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
          stby_r[gi]  <= 8'h00;
          saved_r[gi] <= 8'h00;
        end else begin
          if (wr_done && PADDR_I == mcu_glue_pkg::STBY_OFS + 12'(4 * gi)) begin
            stby_r[gi] <= PWDATA_I[7:0];
          end
          if (nmi_fall) begin
            saved_r[gi] <= stby_r[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (acc) begin
      pready_r  <= 1'b1;
      pslverr_r <= !mapped(PADDR_I);
      prdata_r  <= 32'h0000_0000;
      if (PWRITE_I) begin
        prdata_r <= 32'h0000_0000;
      end else if (PADDR_I == mcu_glue_pkg::PRI_OUT_OFS) begin
        prdata_r <= 32'(pri_out_r);
      end else if (PADDR_I == mcu_glue_pkg::PRI_DIR_OFS) begin
        prdata_r <= 32'(pri_dir_r);
      end else if (PADDR_I == mcu_glue_pkg::PRI_PIN_OFS) begin
        prdata_r <= 32'(PRI_PORT_I);
      end else if (PADDR_I == mcu_glue_pkg::AUX_OUT_OFS) begin
        prdata_r <= 32'(aux_out_r & aux_mask);
      end else if (PADDR_I == mcu_glue_pkg::AUX_DIR_OFS) begin
        prdata_r <= 32'(aux_dir_r);
      end else if (PADDR_I == mcu_glue_pkg::AUX_PIN_OFS) begin
        prdata_r <= 32'(AUX_PORT_I & aux_mask);
      end else if (PADDR_I == mcu_glue_pkg::STATUS_OFS) begin
        prdata_r <= {27'h0, SYNTH_STROBE_O,
                     mode_r == mcu_glue_pkg::MODE_EXPECT, mode_r};
      end else if (PADDR_I == mcu_glue_pkg::EVENT_OFS) begin
        prdata_r <= 32'(ev_r);
      end else if (PADDR_I == mcu_glue_pkg::OUTLATCH_OFS) begin
        prdata_r <= 32'(out_latch_r);
      end else if (PADDR_I == mcu_glue_pkg::SYNTH_OFS) begin
        prdata_r <= 32'(synth_r);
      end else if (PADDR_I >= mcu_glue_pkg::STBY_OFS && PADDR_I < mcu_glue_pkg::SAVED_OFS) begin
        prdata_r <= 32'(stby_r[PADDR_I[SIW+1:2]]);
      end else if (mapped(PADDR_I)) begin
        prdata_r <= 32'(saved_r[PADDR_I[SIW+1:2]]);
      end
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign PREADY_O  = pready_r;
  assign PSLVERR_O = pslverr_r && pready_r;
  assign PRDATA_O  = prdata_r;

endmodule

/* File: mcu_glue_properties.sv */
`timescale 1ns/1ps
// ==========================================================================
// port checker for the board glue block
module mcu_glue_props (
  input wire logic                   CORE_CLK_I,
  input wire logic                   NRST_I,
  input wire logic [4:0]             AUX_PORT_I,
  input wire logic [4:0]             AUX_PORT_O,
  input wire logic [4:0]             AUX_PORT_OE_O,
  input wire logic                   IFACE_IRQ_N_I,
  input wire logic                   MASKABLE_IRQ_N_O,
  input wire logic [7:0]             PROC_DATA_I,
  input wire logic                   SYS_CLK_O,
  input wire logic                   DLY_CLK_O,
  input wire logic                   DECODE_EN_O,
  input wire mcu_glue_pkg::mem_ctl_s MEM_CTL_O,
  input wire logic [7:0]             OUT_PORT_O,
  input wire logic [7:0]             SYNTH_DATA_O,
  input wire logic                   SYNTH_STROBE_O,
  input wire logic [2:0]             MODE_O
);
  logic       prev_r;
  logic       tog_r;
  logic [7:0] cnt_r;
  logic [2:0] strap_w;

  assign strap_w = AUX_PORT_I[2:0];

  // phase length counter; first phase after reset is skipped, it is shorter
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      prev_r <= 1'b0;
      tog_r  <= 1'b0;
      cnt_r  <= 8'h00;
    end else begin
      prev_r <= SYS_CLK_O;
      cnt_r  <= (SYS_CLK_O != prev_r) ? 8'h01 : cnt_r + 8'h01;
      if (SYS_CLK_O != prev_r) tog_r <= 1'b1;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence we_then_fall;
    !MEM_CTL_O.ram_we_n ##1 !SYS_CLK_O;
  endsequence

  // ==========================================================================
  // assertions
  a_irq_and_lines: assert property (
    MASKABLE_IRQ_N_O == (AUX_PORT_I[0] & IFACE_IRQ_N_I)) else $error("irq is not the and");
  a_spare_line_idle: assert property (
    AUX_PORT_OE_O[1] == 1'b0 && AUX_PORT_O[1] == 1'b0) else $error("spare aux line used");
  a_sys_half_period: assert property (
    tog_r && SYS_CLK_O != prev_r |-> cnt_r == 8'h64) else $error("system clock phase length");
  a_dly_clk_copy: assert property (
    DLY_CLK_O == $past(SYS_CLK_O, 2)) else $error("delayed clock misaligned");
  a_reset_no_select: assert property (
    !$past(NRST_I) |-> !DECODE_EN_O && MEM_CTL_O == 4'hf) else $error("select during reset");
  a_decoder_enable_phase: assert property (
    $past(NRST_I) |-> DECODE_EN_O == !DLY_CLK_O) else $error("decoder enable off clock phase");
  a_we_ends_fall: assert property (
    we_then_fall |-> MEM_CTL_O.ram_we_n) else $error("ram write outlives clock fall");
  a_mem_data_phase: assert property (
    !(MEM_CTL_O.ram_cs_n && MEM_CTL_O.rom_ce_n && MEM_CTL_O.ram_oe_n) |-> DLY_CLK_O)
    else $error("memory enabled in address phase");
  a_oport_clk_edge: assert property (
    !$stable(OUT_PORT_O) |-> $past(SYS_CLK_O, 2) && !$past(SYS_CLK_O))
    else $error("output latch moved off clock fall");
  a_synth_holds: assert property (
    !SYNTH_STROBE_O |=> $stable(SYNTH_DATA_O)) else $error("synth latch not holding");
  a_synth_follows: assert property (
    SYNTH_STROBE_O |=> SYNTH_DATA_O == $past(PROC_DATA_I)) else $error("synth latch opaque");
  a_mode_take: assert property (
    $rose(NRST_I) |=> MODE_O == $past(strap_w)) else $error("mode not taken at release");
  a_mode_fixed: assert property (
    $past(NRST_I) |=> $stable(MODE_O)) else $error("mode moved after release");
endmodule

/* File: iface_link_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// far-side link processor, behavioural
module iface_link_model (
  input  wire logic       clk_i,
  input  wire logic       drec_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  output logic            link_data_valid_o,
  output logic            link_direction_o,
  output logic            irq_n_o
);
  initial begin
    data_o            = 8'h00;
    data_oe_o         = 1'b0;
    link_data_valid_o = 1'b1;
    link_direction_o  = 1'b1;
    irq_n_o           = 1'b1;
  end

  // ==========================================================================
  // one byte toward the processor; no clock relation to the processor side
  task automatic offer(input logic [7:0] d, output logic ok);
    int k;
    data_o           <= d;
    data_oe_o        <= 1'b1;
    link_direction_o <= 1'b0;
    irq_n_o          <= 1'b0;
    @(posedge clk_i);
    link_data_valid_o <= 1'b0; // data settled a cycle before valid
    k = 0;
    while (drec_i !== 1'b1 && k < 999) begin
      @(posedge clk_i);
      k++;
    end
    ok = (k < 999);
    data_oe_o         <= 1'b0;
    link_data_valid_o <= 1'b1;
    link_direction_o  <= 1'b1;
    irq_n_o           <= 1'b1;
  endtask
endmodule

/* File: mcu_glue_test.sv */
`timescale 1ns/1ps
// ==========================================================================
// bench for the board glue block
module mcu_glue_test;
  logic        clk, nrst, psel, pen, pwr, pready, pslverr, err, ok;
  logic        kp_n, nmi_n, strap, irq_n, proc_rw, sys_clk;
  logic        mdl_oe, mdl_dval, mdl_dir, mdl_irq_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pri_o, pri_oe, pri_pin, proc_data, out_port, synth_data, mdl_data;
  logic [4:0]  aux_o, aux_oe, aux_pin, aux_ext;
  logic [2:0]  sel_n, mode;
  int          miscompares, total_checks;

  // ==========================================================================
  // board wiring; pull-ups hold every released line high
  assign pri_pin = (pri_oe & pri_o) | (~pri_oe & (mdl_oe ? mdl_data : 8'hff));
  // diodes hold the mode pins at 010 until the capture edge
  assign aux_ext = strap ? {mdl_dir, 4'b1010} : {mdl_dir, 1'b1, mdl_dval, 1'b1, kp_n};
  assign aux_pin = (aux_oe & aux_o) | (~aux_oe & aux_ext);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  mcu_glue u_mcu_glue (
    .CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PRI_PORT_I(pri_pin), .PRI_PORT_O(pri_o), .PRI_PORT_OE_O(pri_oe),
    .AUX_PORT_I(aux_pin), .AUX_PORT_O(aux_o), .AUX_PORT_OE_O(aux_oe),
    .IFACE_IRQ_N_I(mdl_irq_n), .NMI_N_I(nmi_n), .MASKABLE_IRQ_N_O(irq_n),
    .PROC_RW_I(proc_rw), .PROC_DATA_I(proc_data), .RAM_SEL_N_I(sel_n[2]),
    .ROM_SEL_N_I(sel_n[1]), .OPORT_SEL_N_I(sel_n[0]), .SYS_CLK_O(sys_clk), .DLY_CLK_O(),
    .DECODE_EN_O(), .MEM_CTL_O(), .OUT_PORT_O(out_port), .SYNTH_DATA_O(synth_data),
    .SYNTH_STROBE_O(), .MODE_O(mode));

  iface_link_model u_iface_link_model (
    .clk_i(clk), .drec_i(aux_pin[3]), .data_o(mdl_data), .data_oe_o(mdl_oe),
    .link_data_valid_o(mdl_dval), .link_direction_o(mdl_dir), .irq_n_o(mdl_irq_n));

  // ==========================================================================
  // tasks
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bound(input int k);
    if (k >= 999) begin
      miscompares++;
      $display("[ERR] %0t wait timed out", $time);
      finish_test();
    end
  endtask

  task automatic wait_lvl(ref logic s, input logic lvl);
    int k;
    k = 0;
    while (s !== lvl && k < 999) begin
      @(posedge clk);
      k++;
    end
    bound(k);
  endtask

  // one wait-tolerant transfer, request held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 999);
    bound(k);
    rd   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // selects set early in the address phase, dropped after the delayed clock falls
  task automatic bus_cyc(input logic rw, input logic [2:0] seln, input logic [7:0] d);
    wait_lvl(sys_clk, 1'b1);
    wait_lvl(sys_clk, 1'b0);
    proc_rw   <= rw;
    proc_data <= d;
    sel_n     <= seln;
    wait_lvl(sys_clk, 1'b1);
    wait_lvl(sys_clk, 1'b0);
    repeat (4) @(posedge clk);
    sel_n   <= 3'b111;
    proc_rw <= 1'b1;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {nrst, psel, pen, pwr, paddr, pwdata, proc_data} = '0;
    {kp_n, nmi_n, strap, proc_rw, sel_n} = 7'h7f;
    miscompares  = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    strap <= 1'b0;
    @(posedge clk);
    chk({29'h0, mode}, 32'h2);
    rd_chk(mcu_glue_pkg::STATUS_OFS, 32'ha);
    apb(1'b1, mcu_glue_pkg::PRI_DIR_OFS, 32'h0f);
    apb(1'b1, mcu_glue_pkg::PRI_OUT_OFS, 32'ha5);
    chk({16'h0, pri_oe, pri_o}, 32'h0fa5);
    rd_chk(mcu_glue_pkg::PRI_PIN_OFS, 32'hf5);
    rd_chk(mcu_glue_pkg::PRI_OUT_OFS, 32'ha5);
    rd_chk(mcu_glue_pkg::PRI_DIR_OFS, 32'h0f);
    apb(1'b1, mcu_glue_pkg::AUX_OUT_OFS, 32'h1f);
    apb(1'b1, mcu_glue_pkg::AUX_DIR_OFS, 32'h1f);
    chk({22'h0, aux_oe, aux_o}, 32'h3bd);
    rd_chk(mcu_glue_pkg::AUX_PIN_OFS, 32'h1d);
    rd_chk(mcu_glue_pkg::AUX_OUT_OFS, 32'h1d);
    rd_chk(mcu_glue_pkg::AUX_DIR_OFS, 32'h1d);
    apb(1'b1, mcu_glue_pkg::AUX_DIR_OFS, 32'h0);
    apb(1'b1, mcu_glue_pkg::AUX_OUT_OFS, 32'h0);
    apb(1'b1, mcu_glue_pkg::AUX_DIR_OFS, 32'h08);
    apb(1'b1, mcu_glue_pkg::PRI_DIR_OFS, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // the strap pattern itself leaves a keypress edge behind
    apb(1'b1, mcu_glue_pkg::EVENT_OFS, 32'hf);
    kp_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, irq_n}, 32'h0);
    rd_chk(mcu_glue_pkg::EVENT_OFS, 32'h1);
    kp_n <= 1'b1;
    apb(1'b1, mcu_glue_pkg::EVENT_OFS, 32'h1);
    rd_chk(mcu_glue_pkg::EVENT_OFS, 32'h0);
    fork
      u_iface_link_model.offer(8'h5a, ok);
      begin
        wait_lvl(irq_n, 1'b0);
        repeat (2) @(posedge clk);
        rd_chk(mcu_glue_pkg::EVENT_OFS, 32'h2);
        rd_chk(mcu_glue_pkg::PRI_PIN_OFS, 32'h5a);
        rd_chk(mcu_glue_pkg::AUX_PIN_OFS, 32'h01);
        apb(1'b1, mcu_glue_pkg::AUX_OUT_OFS, 32'h08);
      end
    join
    chk({31'h0, ok}, 32'h1);
    repeat (3) @(posedge clk);
    rd_chk(mcu_glue_pkg::EVENT_OFS, 32'ha);
    apb(1'b1, mcu_glue_pkg::EVENT_OFS, 32'hf);
    for (int i = 0; i < mcu_glue_pkg::STBY_WORDS; i++) begin
      apb(1'b1, mcu_glue_pkg::STBY_OFS + 12'(i * 4), 32'(i * 17 + 3));
    end
    nmi_n <= 1'b0;
    repeat (3) @(posedge clk);
    nmi_n <= 1'b1;
    apb(1'b1, mcu_glue_pkg::STBY_OFS, 32'hee);
    rd_chk(mcu_glue_pkg::STBY_OFS, 32'hee);
    for (int i = 0; i < mcu_glue_pkg::STBY_WORDS; i++) begin
      rd_chk(mcu_glue_pkg::SAVED_OFS + 12'(i * 4), 32'(i * 17 + 3));
    end
    rd_chk(mcu_glue_pkg::EVENT_OFS, 32'h4);
    bus_cyc(1'b0, 3'b110, 8'ha5);
    chk({16'h0, out_port, synth_data}, 32'ha5a5);
    proc_data <= 8'h3c;
    repeat (2) @(posedge clk);
    chk({24'h0, synth_data}, 32'h3c);
    bus_cyc(1'b0, 3'b110, 8'h42);
    proc_data <= 8'h99;
    repeat (2) @(posedge clk);
    chk({16'h0, out_port, synth_data}, 32'h4242);
    rd_chk(mcu_glue_pkg::OUTLATCH_OFS, 32'h42);
    rd_chk(mcu_glue_pkg::SYNTH_OFS, 32'h42);
    bus_cyc(1'b0, 3'b011, 8'h77);
    bus_cyc(1'b1, 3'b011, 8'h00);
    bus_cyc(1'b1, 3'b101, 8'h00);
    chk({21'h0, out_port, mode}, 32'h212);
    finish_test();
  end
endmodule

bind mcu_glue mcu_glue_props u_mcu_glue_props (
  .CORE_CLK_I, .NRST_I, .AUX_PORT_I, .AUX_PORT_O, .AUX_PORT_OE_O, .IFACE_IRQ_N_I,
  .MASKABLE_IRQ_N_O, .PROC_DATA_I, .SYS_CLK_O, .DLY_CLK_O, .DECODE_EN_O, .MEM_CTL_O,
  .OUT_PORT_O, .SYNTH_DATA_O, .SYNTH_STROBE_O, .MODE_O);
